//--- verilog/p7io_pkg.sv
package p7io_pkg;
    // Register indices as printed; APB byte address is four times the index
    localparam logic [15:0] IDX_PORT_CTL = 16'hFE5C;
    localparam logic [15:0] IDX_INT01_CTL = 16'hFE5D;
    localparam logic [15:0] IDX_INT23_CTL = 16'hFE5E;
    localparam logic [15:0] IDX_SIG_SEL = 16'hFE5F;
    // Added registers for bus-side interrupt, standby control and latch view
    localparam logic [15:0] IDX_EVT_STATUS = 16'hFE60;
    localparam logic [15:0] IDX_EVT_MASK = 16'hFE61;
    localparam logic [15:0] IDX_PWR_CTL = 16'hFE62;
    localparam logic [15:0] IDX_PORT_LATCH = 16'hFE63;
    // Reset values
    localparam logic [7:0] RST_PORT_CTL = 8'h00;
    localparam logic [7:0] RST_INT01_CTL = 8'h00;
    localparam logic [7:0] RST_INT23_CTL = 8'h00;
    localparam logic [7:0] RST_SIG_SEL = 8'h00;
    localparam logic [3:0] RST_EVT = 4'h0;
    // Port control fields
    localparam int PORT_DATA_LSB = 0;
    localparam int PORT_DIR_LSB = 4;
    // Interrupt control fields, per half of a control byte (add 4 for upper half)
    localparam int INT_IE_POS = 0;
    localparam int INT_IF_POS = 1;
    localparam int INT_LV_POS = 2;
    localparam int INT_LH_POS = 3;
    localparam int INT_FALL_POS = 2;
    localparam int INT_RISE_POS = 3;
    localparam int INT_HALF = 4;
    // Signal select fields
    localparam int SEL_COUNT_POS = 0;
    localparam int SEL_LOW_CAP_POS = 6;
    localparam int SEL_HIGH_CAP_POS = 7;
    // Power control fields
    localparam int PWR_DEEP_POS = 0;
    localparam int PWR_LIGHT_POS = 1;
    // Standby states
    typedef enum logic [1:0] {ST_NORMAL, ST_DEEP, ST_LIGHT} p7io_pwr_t;
endpackage : p7io_pkg

//--- verilog/p7io_detect.sv
`timescale 1ns/1ps
// One pin's condition detector: level or edge, with per-edge blocking
module p7io_detect (
    input wire logic cur,
    input wire logic prev,
    input wire logic level_en,
    input wire logic level_high,
    input wire logic rise_en,
    input wire logic fall_en,
    input wire logic block_rise,
    input wire logic block_fall,
    output logic hit
);
    logic rise;
    logic fall;

    // Edges seen against the previous cycle's sample
    assign rise = cur & ~prev;
    assign fall = ~cur & prev;
    // Level mode fires every cycle the level holds
    assign hit = level_en ? (cur == level_high)
        : ((rise_en & ~block_rise & rise) | (fall_en & ~block_fall & fall));
endmodule : p7io_detect

//--- verilog/p7io_port.sv
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
module p7io_port (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] pin_in,
    output logic [3:0] pin_out,
    output logic [3:0] pin_oe_n,
    output logic [3:0] pullup_en,
    output logic [3:0] irq_req,
    input wire logic int_accept,
    output logic timer_count_pulse,
    output logic low_capture_strobe,
    output logic high_capture_strobe,
    output logic standby_release,
    output logic deep_standby,
    output logic light_standby,
    output logic irq
);
    // Stored registers
    logic [7:0] port_ctl; // Data low nibble, direction high nibble
    logic [7:0] int01_ctl; // Interrupt zero/one control
    logic [7:0] int23_ctl; // Interrupt two/three control
    logic [7:0] sig_sel; // Timer input selection
    logic [3:0] evt_status; // Sticky detection events, cleared by read
    logic [3:0] evt_mask; // Gates events onto irq
    logic [3:0] pin_prev; // Last cycle pin levels for edge finding
    logic pin2_entry; // Pin two level caught on deep standby entry
    p7io_pkg::p7io_pwr_t pwr_state;
    // Bus decode
    logic setup_ph;
    logic access_ph;
    logic [15:0] idx;
    logic wr_en;
    logic rd_done;
    logic [31:0] next_prdata;
    logic next_slverr;
    logic [7:0] next_int01;
    logic [7:0] next_int23;
    // Detection
    logic [3:0] hit;
    logic [3:0] lvl_en;
    logic [3:0] lvl_hi;
    logic [3:0] rise_en;
    logic [3:0] fall_en;
    logic [3:0] blk_rise;
    logic [3:0] blk_fall;
    logic [3:0] flag;
    logic [3:0] ena;
    logic wake;

    assign setup_ph = psel & ~penable;
    // Access completes only on the edge where our pready is seen high
    assign access_ph = psel & penable & pready;
    assign idx = paddr[17:2];
    assign wr_en = access_ph & pwrite;
    assign rd_done = access_ph & ~pwrite;

    // Flag and enable views of both control bytes
    assign flag = {int23_ctl[p7io_pkg::INT_IF_POS + p7io_pkg::INT_HALF],
                   int23_ctl[p7io_pkg::INT_IF_POS],
                   int01_ctl[p7io_pkg::INT_IF_POS + p7io_pkg::INT_HALF],
                   int01_ctl[p7io_pkg::INT_IF_POS]};
    assign ena = {int23_ctl[p7io_pkg::INT_IE_POS + p7io_pkg::INT_HALF],
                  int23_ctl[p7io_pkg::INT_IE_POS],
                  int01_ctl[p7io_pkg::INT_IE_POS + p7io_pkg::INT_HALF],
                  int01_ctl[p7io_pkg::INT_IE_POS]};

    // Per-pin detector configuration
    always_comb
    begin
        lvl_en[0] = int01_ctl[p7io_pkg::INT_LV_POS];
        lvl_hi[0] = int01_ctl[p7io_pkg::INT_LH_POS];
        lvl_en[1] = int01_ctl[p7io_pkg::INT_LV_POS + p7io_pkg::INT_HALF];
        lvl_hi[1] = int01_ctl[p7io_pkg::INT_LH_POS + p7io_pkg::INT_HALF];
        // edge polarity from the same bits
        rise_en[0] = lvl_hi[0] & ~lvl_en[0];
        fall_en[0] = ~lvl_hi[0] & ~lvl_en[0];
        rise_en[1] = lvl_hi[1] & ~lvl_en[1];
        fall_en[1] = ~lvl_hi[1] & ~lvl_en[1];
        // pins two and three are edge only
        lvl_en[3:2] = 2'h0;
        lvl_hi[3:2] = 2'h0;
        rise_en[2] = int23_ctl[p7io_pkg::INT_RISE_POS];
        fall_en[2] = int23_ctl[p7io_pkg::INT_FALL_POS];
        rise_en[3] = int23_ctl[p7io_pkg::INT_RISE_POS + p7io_pkg::INT_HALF];
        fall_en[3] = int23_ctl[p7io_pkg::INT_FALL_POS + p7io_pkg::INT_HALF];
        // pin two edge blocked by entry level
        blk_rise = 4'h0;
        blk_fall = 4'h0;
        blk_rise[2] = (pwr_state == p7io_pkg::ST_DEEP) & pin2_entry;
        blk_fall[2] = (pwr_state == p7io_pkg::ST_DEEP) & ~pin2_entry;
    end

    // One detector per pin
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_det
            p7io_detect u_det (
                .cur(pin_in[gi]),
                .prev(pin_prev[gi]),
                .level_en(lvl_en[gi]),
                .level_high(lvl_hi[gi]),
                .rise_en(rise_en[gi]),
                .fall_en(fall_en[gi]),
                .block_rise(blk_rise[gi]),
                .block_fall(blk_fall[gi]),
                .hit(hit[gi])
            );
        end
    endgenerate

    // Pin history
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pin_prev <= 4'h0;
        else
            pin_prev <= pin_in;
    end

    // Next values of the interrupt control bytes; hardware set beats clear
    always_comb
    begin
        next_int01 = int01_ctl;
        next_int23 = int23_ctl;
        if (wr_en && idx == p7io_pkg::IDX_INT01_CTL)
            next_int01 = pwdata[7:0];
        if (wr_en && idx == p7io_pkg::IDX_INT23_CTL)
            next_int23 = pwdata[7:0];
        next_int01[p7io_pkg::INT_IF_POS] = next_int01[p7io_pkg::INT_IF_POS] | hit[0];
        next_int01[p7io_pkg::INT_IF_POS + p7io_pkg::INT_HALF] =
            next_int01[p7io_pkg::INT_IF_POS + p7io_pkg::INT_HALF] | hit[1];
        next_int23[p7io_pkg::INT_IF_POS] = next_int23[p7io_pkg::INT_IF_POS] | hit[2];
        next_int23[p7io_pkg::INT_IF_POS + p7io_pkg::INT_HALF] =
            next_int23[p7io_pkg::INT_IF_POS + p7io_pkg::INT_HALF] | hit[3];
    end

    // Interrupt control registers; flags only drop by a software write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            int01_ctl <= p7io_pkg::RST_INT01_CTL;
            int23_ctl <= p7io_pkg::RST_INT23_CTL;
        end
        else
        begin
            int01_ctl <= next_int01;
            int23_ctl <= next_int23;
        end
    end

    // Port and selection registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            port_ctl <= p7io_pkg::RST_PORT_CTL;
            sig_sel <= p7io_pkg::RST_SIG_SEL;
            evt_mask <= p7io_pkg::RST_EVT;
        end
        else if (wr_en)
        begin
            // data and direction in one byte
            if (idx == p7io_pkg::IDX_PORT_CTL)
                port_ctl <= pwdata[7:0];
            if (idx == p7io_pkg::IDX_SIG_SEL)
                sig_sel <= pwdata[7:0];
            if (idx == p7io_pkg::IDX_EVT_MASK)
                evt_mask <= pwdata[3:0];
        end
    end

    // Sticky event status; an event in the clearing read's cycle survives
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            evt_status <= p7io_pkg::RST_EVT;
        else if (rd_done && idx == p7io_pkg::IDX_EVT_STATUS)
            evt_status <= hit;
        else
            evt_status <= evt_status | hit;
    end

    // Interrupt output from the gated status
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |(evt_status & evt_mask);
    end

    // Pin drivers, one cycle behind the register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_out <= 4'h0;
            pin_oe_n <= 4'hF;
            pullup_en <= 4'h0;
        end
        else
        begin
            pin_out <= port_ctl[p7io_pkg::PORT_DATA_LSB +: 4];
            pin_oe_n[3:1] <= ~port_ctl[p7io_pkg::PORT_DIR_LSB + 1 +: 3];
            pin_oe_n[0] <= ~(port_ctl[p7io_pkg::PORT_DIR_LSB]
                & ~port_ctl[p7io_pkg::PORT_DATA_LSB]);
            pullup_en <= port_ctl[p7io_pkg::PORT_DATA_LSB +: 4];
        end
    end

    // Interrupt requests to the core
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_req <= 4'h0;
        else
            irq_req <= flag & ena;
    end

    // Timer strobes; level mode keeps hit high so strobes repeat each cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            timer_count_pulse <= 1'b0;
            low_capture_strobe <= 1'b0;
            high_capture_strobe <= 1'b0;
        end
        else
        begin
            timer_count_pulse <= sig_sel[p7io_pkg::SEL_COUNT_POS] ? hit[3] : hit[2];
            // low capture source select, pin zero hit or pin two edge hit
            low_capture_strobe <= sig_sel[p7io_pkg::SEL_LOW_CAP_POS] ? hit[0] : hit[2];
            // high capture source select, pin one hit or pin three edge hit
            high_capture_strobe <= sig_sel[p7io_pkg::SEL_HIGH_CAP_POS] ? hit[1] : hit[3];
        end
    end

    // pins zero, one wake in level mode
    assign wake = (flag[0] & ena[0] & lvl_en[0]) | (flag[1] & ena[1] & lvl_en[1])
        | (flag[2] & ena[2]);

    // Standby sequencer: deep, then light after release, normal on accept
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pwr_state <= p7io_pkg::ST_NORMAL;
            standby_release <= 1'b0;
        end
        else
        begin
            standby_release <= 1'b0;
            unique case (pwr_state)
                p7io_pkg::ST_NORMAL:
                begin
                    if (wr_en && idx == p7io_pkg::IDX_PWR_CTL
                        && pwdata[p7io_pkg::PWR_DEEP_POS])
                        pwr_state <= p7io_pkg::ST_DEEP;
                end
                p7io_pkg::ST_DEEP:
                begin
                    if (wake)
                    begin
                        pwr_state <= p7io_pkg::ST_LIGHT;
                        standby_release <= 1'b1;
                    end
                end
                p7io_pkg::ST_LIGHT:
                begin
                    if (int_accept)
                        pwr_state <= p7io_pkg::ST_NORMAL;
                end
                default:
                    pwr_state <= p7io_pkg::ST_NORMAL;
            endcase
        end
    end

    // Mode flags as outputs, and pin two caught on entry
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            deep_standby <= 1'b0;
            light_standby <= 1'b0;
            pin2_entry <= 1'b0;
        end
        else
        begin
            deep_standby <= (pwr_state == p7io_pkg::ST_DEEP);
            light_standby <= (pwr_state == p7io_pkg::ST_LIGHT);
            if (pwr_state == p7io_pkg::ST_NORMAL)
                pin2_entry <= pin_in[2];
        end
    end

    // Read mux, sampled in the setup cycle
    always_comb
    begin
        next_prdata = 32'h0000_0000;
        next_slverr = 1'b0;
        unique case (idx)
            p7io_pkg::IDX_PORT_CTL:
                next_prdata[7:0] = {port_ctl[p7io_pkg::PORT_DIR_LSB +: 4], pin_in};
            p7io_pkg::IDX_INT01_CTL: next_prdata[7:0] = int01_ctl;
            p7io_pkg::IDX_INT23_CTL: next_prdata[7:0] = int23_ctl;
            p7io_pkg::IDX_SIG_SEL: next_prdata[7:0] = sig_sel;
            p7io_pkg::IDX_EVT_STATUS: next_prdata[3:0] = evt_status;
            p7io_pkg::IDX_EVT_MASK: next_prdata[3:0] = evt_mask;
            p7io_pkg::IDX_PWR_CTL:
            begin
                next_prdata[p7io_pkg::PWR_DEEP_POS] = (pwr_state == p7io_pkg::ST_DEEP);
                next_prdata[p7io_pkg::PWR_LIGHT_POS] = (pwr_state == p7io_pkg::ST_LIGHT);
            end
            p7io_pkg::IDX_PORT_LATCH: next_prdata[7:0] = port_ctl;
            default: next_slverr = 1'b1;
        endcase
    end

    // APB answer: one wait-free access cycle after setup
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= setup_ph;
            if (setup_ph)
            begin
                prdata <= pwrite ? 32'h0000_0000 : next_prdata;
                pslverr <= next_slverr;
            end
        end
    end

    // a_pin0_opendrain: a driven one never drives pin zero
    a_pin0_opendrain: assert property (@(posedge pclk) disable iff (!presetn)
        pin_out[0] |-> pin_oe_n[0])
        else $error("pin zero driven while data one");
    a_pullup_data: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 pullup_en == $past(port_ctl[3:0]))
        else $error("pull-up does not follow data");
    a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        flag[0] && !(wr_en && idx == p7io_pkg::IDX_INT01_CTL) |=> flag[0])
        else $error("flag zero dropped without write");
    a_level_repeat: assert property (@(posedge pclk) disable iff (!presetn)
        (lvl_en[0] && sig_sel[6] && pin_in[0] == lvl_hi[0]) [*2]
        |=> low_capture_strobe && $past(low_capture_strobe))
        else $error("low capture not repeated");
    a_high_cap_route: assert property (@(posedge pclk) disable iff (!presetn)
        !sig_sel[7] && $rose(pin_in[3]) && int23_ctl[7] |=> high_capture_strobe)
        else $error("high capture missed pin three rise");
    a_count_edge: assert property (@(posedge pclk) disable iff (!presetn)
        !sig_sel[0] && $fell(pin_in[2]) && int23_ctl[2]
        && pwr_state != p7io_pkg::ST_DEEP |=> timer_count_pulse)
        else $error("count pulse missed pin two fall");
    a_edge_no_wake: assert property (@(posedge pclk) disable iff (!presetn)
        pwr_state == p7io_pkg::ST_DEEP && !lvl_en[0] && !lvl_en[1] && !(flag[2] && ena[2])
        |=> pwr_state == p7io_pkg::ST_DEEP)
        else $error("edge-mode pin woke deep standby");
    a_wake_light: assert property (@(posedge pclk) disable iff (!presetn)
        pwr_state == p7io_pkg::ST_DEEP && flag[2] && ena[2]
        |=> standby_release ##1 light_standby)
        else $error("wake did not reach light standby");
    a_pin2_block: assert property (@(posedge pclk) disable iff (!presetn)
        pwr_state == p7io_pkg::ST_DEEP && pin2_entry && $rose(pin_in[2])
        && !int23_ctl[2] |-> !hit[2])
        else $error("pin two rise not blocked");
    a_read_pins: assert property (@(posedge pclk) disable iff (!presetn)
        setup_ph && !pwrite && idx == p7io_pkg::IDX_PORT_CTL
        |=> prdata[3:0] == $past(pin_in))
        else $error("port read not live pins");
    c_level_wake: cover property (@(posedge pclk) disable iff (!presetn)
        deep_standby ##1 standby_release ##[1:20] !light_standby);
    c_both_edges: cover property (@(posedge pclk) disable iff (!presetn)
        timer_count_pulse ##[1:20] timer_count_pulse);
    c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
    c_slverr: cover property (@(posedge pclk) disable iff (!presetn) pready && pslverr);
endmodule : p7io_port

//--- testbench/p7io_pins.sv
`timescale 1ns/1ps
// Far-side pin model: external sources, pull-ups and floating lines
module p7io_pins (
    input wire logic pclk,
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe_n,
    input wire logic [3:0] pullup_en,
    input wire logic [3:0] ext_en,
    input wire logic [3:0] ext_val,
    output logic [3:0] pin_in
);
    logic [3:0] last; // Level seen last cycle
    // Resolve each wire: design drive, then source, then pull-up
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            if (!pin_oe_n[i])
                pin_in[i] = pin_out[i];
            else if (ext_en[i])
                pin_in[i] = ext_val[i];
            else if (pullup_en[i])
                pin_in[i] = 1'b1;
            else
                // A floating line must not keep its old value
                pin_in[i] = ~last[i];
        end
    end
    // Remember the level for the floating case
    always_ff @(posedge pclk)
        last <= pin_in;
endmodule : p7io_pins

//--- testbench/test_p7io_port.sv
`timescale 1ns/1ps
// Bench for the four-pin port: registers, pins, interrupts, standby
module test_p7io_port;
    logic pclk, presetn, psel, penable, pwrite, int_accept, pready, pslverr, err;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pin_in, pin_out, pin_oe_n, pullup_en, irq_req, ext_val, ext_en;
    logic timer_count_pulse, low_capture_strobe, high_capture_strobe;
    logic standby_release, deep_standby, light_standby, irq;
    int bad_count = 0, n_checks = 0, n_cnt = 0, n_lo = 0, n_hi = 0, n_rel = 0, c0, c1, c2;
    // Port rows: control byte, read-back, expected drive enables, pull-ups
    typedef struct {logic [7:0] ctl; logic [7:0] rdv; logic [3:0] oe; logic [3:0] pu;} p7io_row_t;
    p7io_row_t rows [5] = '{'{8'h00, 8'h0A, 4'hF, 4'h0}, '{8'h0F, 8'h0A, 4'hF, 4'hF},
        '{8'hF0, 8'hF0, 4'h0, 4'h0}, '{8'hFF, 8'hFE, 4'h1, 4'hF}, '{8'h35, 8'h38, 4'hD, 4'h5}};

    p7io_port i_p7io_port (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pullup_en(pullup_en), .irq_req(irq_req), .int_accept(int_accept),
        .timer_count_pulse(timer_count_pulse), .low_capture_strobe(low_capture_strobe),
        .high_capture_strobe(high_capture_strobe), .standby_release(standby_release),
        .deep_standby(deep_standby), .light_standby(light_standby), .irq(irq));
    p7io_pins i_p7io_pins (.pclk(pclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pullup_en(pullup_en), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

    // Clock, 20 ns period
    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // Pulse counters sample mid-cycle, clear of the clock edge
    always @(negedge pclk)
    begin
        n_cnt += timer_count_pulse;
        n_lo += low_capture_strobe;
        n_hi += high_capture_strobe;
        n_rel += standby_release;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; registers sit at consecutive word indices
    task automatic apb(input logic w, input int k, input logic [7:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {p7io_pkg::IDX_PORT_CTL + 16'(k), 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim

    // Watchdog: the whole run needs well under this span
    initial
    begin
        repeat (8000) @(posedge pclk);
        bad_count++;
        end_sim();
    end

    initial
    begin
        {presetn, psel, penable, pwrite, int_accept} = 5'h00;
        paddr = 18'h00000;
        pwdata = 32'h00000000;
        ext_val = 4'hA;
        ext_en = 4'hF;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(pin_oe_n, 4'hF); // released after reset
        for (int k = 1; k < 4; k++)
        begin
            apb(1'b0, k, 8'h00);
            chk(rd, 32'h0); // reset values
        end
        // Ordinary cases: drive, pull-up and read-back per row
        foreach (rows[i])
        begin
            apb(1'b1, 0, rows[i].ctl);
            repeat (2) @(posedge pclk);
            chk(pin_oe_n, rows[i].oe);
            chk(pullup_en, rows[i].pu);
            chk(pin_out, rows[i].ctl[3:0]);
            apb(1'b0, 0, 8'h00);
            chk(rd, rows[i].rdv);
            apb(1'b0, 7, 8'h00);
            chk(rd, rows[i].ctl);
        end
        apb(1'b1, 0, 8'h00);
        $display("port rows done");
        // Every polarity and level code on pins zero and one
        for (int m = 0; m < 4; m++)
        begin
            ext_val <= 4'h0;
            repeat (3) @(posedge pclk);
            // Old level mode may set a flag at the first write; the second clears it
            apb(1'b1, 1, 8'((m << 2) | (m << 6)));
            apb(1'b1, 1, 8'((m << 2) | (m << 6)));
            apb(1'b0, 1, 8'h00);
            chk(rd & 32'h22, (m == 1) ? 32'h22 : 32'h0);
            ext_val <= 4'h3;
            repeat (3) @(posedge pclk);
            apb(1'b0, 1, 8'h00);
            chk(rd & 32'h22, (m != 0) ? 32'h22 : 32'h0);
            ext_val <= 4'h0;
            repeat (3) @(posedge pclk);
            apb(1'b0, 1, 8'h00);
            chk(rd & 32'h22, 32'h22);
        end
        // Level mode: capture strobes repeat every cycle
        apb(1'b1, 3, 8'hC0);
        apb(1'b1, 1, 8'hCC);
        ext_val <= 4'h3;
        repeat (3) @(posedge pclk);
        c0 = n_lo;
        c1 = n_hi;
        repeat (8) @(posedge pclk);
        chk(n_lo - c0, 8);
        chk(n_hi - c1, 8);
        $display("pin zero and one modes done");
        // Edge codes on pins two and three, each as count source
        for (int p = 2; p < 4; p++)
        begin
            for (int m = 0; m < 4; m++)
            begin
                ext_val <= 4'h0;
                apb(1'b1, 3, 8'(p - 2));
                apb(1'b1, 2, 8'(m << ((p == 2) ? 2 : 6)));
                c0 = n_cnt;
                c1 = n_lo;
                c2 = n_hi;
                ext_val <= 4'(1 << p);
                repeat (3) @(posedge pclk);
                ext_val <= 4'h0;
                repeat (3) @(posedge pclk);
                chk(n_cnt - c0, m[0] + m[1]);
                chk((p == 2) ? n_lo - c1 : n_hi - c2, m[0] + m[1]);
                apb(1'b0, 2, 8'h00);
                chk(rd[(p == 2) ? 1 : 5], m != 0);
            end
        end
        $display("pin two and three modes done");
        // Interrupt: raise, read-clear, mask
        apb(1'b0, 4, 8'h00);
        apb(1'b1, 5, 8'h04);
        apb(1'b1, 2, 8'h0D);
        ext_val <= 4'h4;
        repeat (3) @(posedge pclk);
        chk(irq_req, 4'h4);
        chk(irq, 1'b1);
        apb(1'b0, 4, 8'h00);
        chk(rd, 32'h4);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0);
        apb(1'b1, 5, 8'h00);
        ext_val <= 4'h0;
        repeat (3) @(posedge pclk);
        chk(irq, 1'b0);
        $display("interrupt done");
        // Standby: edge on pin zero keeps sleep, blocked edge, then wake
        ext_val <= 4'h5;
        repeat (3) @(posedge pclk);
        // High level mode still hits at the first write; the second clears flag zero
        apb(1'b1, 1, 8'h01);
        apb(1'b1, 1, 8'h01);
        apb(1'b1, 2, 8'h09);
        apb(1'b1, 6, 8'h01);
        repeat (3) @(posedge pclk);
        chk(deep_standby, 1'b1);
        apb(1'b0, 6, 8'h00);
        chk(rd, 32'h1);
        ext_val <= 4'h4;
        repeat (3) @(posedge pclk);
        chk(irq_req, 4'h1);
        chk(deep_standby, 1'b1);
        ext_val <= 4'h0;
        repeat (3) @(posedge pclk);
        ext_val <= 4'h4;
        repeat (3) @(posedge pclk);
        chk(irq_req, 4'h1);
        chk(deep_standby, 1'b1);
        apb(1'b1, 2, 8'h0D);
        c0 = n_rel;
        ext_val <= 4'h0;
        // Flag, then state, then the registered mode flag: three edges of lag
        repeat (4) @(posedge pclk);
        chk(n_rel - c0, 1);
        chk({deep_standby, light_standby}, 2'b01);
        int_accept <= 1'b1;
        @(posedge pclk);
        int_accept <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(light_standby, 1'b0);
        // Released pin three rests on its pull-up
        apb(1'b1, 0, 8'h08);
        ext_en <= 4'h7;
        repeat (2) @(posedge pclk);
        apb(1'b0, 0, 8'h00);
        chk(rd, 32'h08);
        // Unmapped index is refused
        apb(1'b0, 20, 8'h00);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        $display("standby and refusal done");
        end_sim();
    end
endmodule : test_p7io_port
